/* File: core/cdra_pkg.sv */
// Package of offsets, field positions and carrier types for the alarm status and interrupt block.
// Summary of operation
// [R1] One status register per channel at fixed offsets.
// [R2] Bit 5 shows live loss-of-lock state.
// [R3] Bit 4 shows live signal-loss alarm.
// [R4] Bit 1 sets on lock change, clears on read.
// [R5] Bit 0 sets on signal change, clears on read.
// [R6] Lock flag interrupts only when its enable set.
// [R7] Signal flag interrupts only when its enable set.
// [R8] Bits 7,6,3,2 read zero; all reset zero.
// [R9] Enable bits mask when 0; default 0.
// [R10] Interrupt holds while any enabled flag set.
// [R11] Host reads status to learn and clear cause.
package cdra_pkg;

    localparam int          CDRA_NUM_CH       = 4;
    localparam int          CDRA_ADDR_W       = 8;
    localparam int          CDRA_DATA_W       = 8;

    // Byte offsets of the per-channel status registers.
    localparam logic [7:0]  CDRA_CH0_OFFS     = 8'h0A;
    localparam logic [7:0]  CDRA_CH1_OFFS     = 8'h12;
    localparam logic [7:0]  CDRA_CH2_OFFS     = 8'h1A;
    localparam logic [7:0]  CDRA_CH3_OFFS     = 8'h22;

    // Field positions inside a status register.
    localparam int          CDRA_LOCK_LOST_BIT   = 5;
    localparam int          CDRA_SIGNAL_LOST_BIT = 4;
    localparam int          CDRA_LOCK_CHG_BIT    = 1;
    localparam int          CDRA_SIGNAL_CHG_BIT  = 0;

    // Value after reset and value read at unmapped addresses.
    localparam logic [7:0]  CDRA_STATUS_RESET = 8'h00;
    localparam logic [7:0]  CDRA_UNMAPPED_VAL = 8'h00;

    // Read request from the host side of the control interface.
    typedef struct packed {
        logic                   en;
        logic [CDRA_ADDR_W-1:0] addr;
    } cdra_rd_req_s;

    // Read answer back to the host side.
    typedef struct packed {
        logic                   valid;
        logic [CDRA_DATA_W-1:0] data;
    } cdra_rd_rsp_s;

endpackage

/* File: core/cdra_change_det.sv */
// Change detector: flags any bit of a level vector that differs from its last sampled value.
`timescale 1ns/1ps
module cdra_change_det
    import cdra_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Level in, one-cycle change pulses out.
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] changed
);

    typedef struct packed {
        logic         primed;
        logic [W-1:0] prev;
    } cdra_det_state_s;

    cdra_det_state_s st_q;
    cdra_det_state_s st_d;

    // The first sample after reset only primes the history, so a status that is
    // already asserted out of reset is not reported as a change.
    always_comb begin
        st_d        = st_q;
        st_d.primed = 1'b1;
        st_d.prev   = level;
    end

    assign changed = st_q.primed ? (level ^ st_q.prev) : '0;

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule // cdra_change_det

/* File: core/cdra_flag_bank.sv */
// Bank of sticky flags: hardware sets, read clears, a set in the clearing cycle wins.
`timescale 1ns/1ps
module cdra_flag_bank
    import cdra_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Set and clear requests.
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Held flags.
    output logic      [W-1:0] flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } cdra_flag_state_s;

    cdra_flag_state_s st_q;
    cdra_flag_state_s st_d;

    // Set beats clear so a change arriving during the clearing read is kept.
    always_comb begin
        st_d       = st_q;
        st_d.flags = (st_q.flags & ~clr) | set; // [R4] [R5] [R10]
    end

    assign flags = st_q.flags;

    // State register; flags are zero after reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0; // [R8]
        end else begin
            st_q <= st_d;
        end
    end

endmodule // cdra_flag_bank

/* File: core/cdra_alarm_irq.sv */
// Top of the per-channel alarm status and interrupt status register block.
`timescale 1ns/1ps
module cdra_alarm_irq
    import cdra_pkg::*;
#(
    parameter int NUM_CH = CDRA_NUM_CH
) (
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Live detector levels, one bit per channel.
    input  wire logic [NUM_CH-1:0]   lock_lost_state,
    input  wire logic [NUM_CH-1:0]   signal_lost_state,
    // Enable bits from the per-channel configuration registers.
    input  wire logic [NUM_CH-1:0]   lock_change_irq_enable,
    input  wire logic [NUM_CH-1:0]   signal_change_irq_enable,
    // Register read port of the control interface.
    input  wire cdra_rd_req_s        rd_req,
    output cdra_rd_rsp_s             rd_rsp,
    // External interrupt, active high.
    output logic                     irq
);

    typedef struct packed {
        cdra_rd_rsp_s rsp;
        logic         irq;
    } cdra_top_state_s;

    localparam logic [3:0][7:0] CH_OFFS = {CDRA_CH3_OFFS, CDRA_CH2_OFFS, CDRA_CH1_OFFS, CDRA_CH0_OFFS};

    cdra_top_state_s   st_q;
    cdra_top_state_s   st_d;
    logic [NUM_CH-1:0] lock_chg;
    logic [NUM_CH-1:0] signal_chg;
    logic [NUM_CH-1:0] lock_change_flag;
    logic [NUM_CH-1:0] signal_change_flag;
    logic [NUM_CH-1:0] ch_hit;

    // Address decode: one hit line per channel register.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ch_hit[i] = rd_req.en && (rd_req.addr == CH_OFFS[i]); // [R1]
        end
    end

    // Edge detection on the live detector levels.
    cdra_change_det #(.W(NUM_CH)) u_lock_det (
        .ref_clk (ref_clk),
        .rst     (rst),
        .level   (lock_lost_state),
        .changed (lock_chg)
    );

    cdra_change_det #(.W(NUM_CH)) u_signal_det (
        .ref_clk (ref_clk),
        .rst     (rst),
        .level   (signal_lost_state),
        .changed (signal_chg)
    );

    // Sticky change flags; a read of a channel register clears both of its flags.
    cdra_flag_bank #(.W(NUM_CH)) u_lock_flags (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (lock_chg),    // [R4]
        .clr     (ch_hit),      // [R11]
        .flags   (lock_change_flag)
    );

    cdra_flag_bank #(.W(NUM_CH)) u_signal_flags (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (signal_chg),  // [R5]
        .clr     (ch_hit),      // [R11]
        .flags   (signal_change_flag)
    );

    // Read data is captured in the request cycle, so the host sees the flag
    // value before the clear takes effect. Unmapped addresses answer zero.
    always_comb begin
        st_d           = st_q;
        st_d.rsp.valid = rd_req.en;
        st_d.rsp.data  = CDRA_UNMAPPED_VAL; // [R8]
        for (int i = 0; i < NUM_CH; i++) begin
            if (ch_hit[i]) begin
                st_d.rsp.data[CDRA_LOCK_LOST_BIT]   = lock_lost_state[i];    // [R2]
                st_d.rsp.data[CDRA_SIGNAL_LOST_BIT] = signal_lost_state[i];  // [R3]
                st_d.rsp.data[CDRA_LOCK_CHG_BIT]    = lock_change_flag[i];   // [R4]
                st_d.rsp.data[CDRA_SIGNAL_CHG_BIT]  = signal_change_flag[i]; // [R5]
            end
        end
        // Enables at zero mask their flag; the output stays up while any enabled flag is held.
        st_d.irq = |(lock_change_flag & lock_change_irq_enable)       // [R6] [R9] [R10]
                 | |(signal_change_flag & signal_change_irq_enable);  // [R7] [R9] [R10]
    end

    assign rd_rsp = st_q.rsp;
    assign irq    = st_q.irq;

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0; // [R8]
        end else begin
            st_q <= st_d;
        end
    end

endmodule // cdra_alarm_irq

/* File: verif/cdra_alarm_irq_chk.sv */
// Checker of the alarm status block ports.
`timescale 1ns/1ps
module cdra_alarm_irq_chk
    import cdra_pkg::*;
#(parameter int NUM_CH = CDRA_NUM_CH) (
    // Watched ports.
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [NUM_CH-1:0] lock_lost_state,
    input wire logic [NUM_CH-1:0] signal_lost_state,
    input wire logic [NUM_CH-1:0] lock_change_irq_enable,
    input wire logic [NUM_CH-1:0] signal_change_irq_enable,
    input wire cdra_rd_req_s      rd_req,
    input wire cdra_rd_rsp_s      rd_rsp,
    input wire logic              irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Only offsets 8 apart from channel 0 up to channel 3 hit a register.
    wire [7:0] off = rd_req.addr - CDRA_CH0_OFFS;
    wire       hit = off[2:0] == 3'h0 && off <= 8'h18;
    wire [1:0] ci  = off[4:3];
    logic      prim_q;
    // Change history is meaningless before the first edge after reset.
    always_ff @(posedge ref_clk or posedge rst) prim_q <= !rst;
    a_rsp_follows: assert property (rd_req.en |=> rd_rsp.valid)
        else $error("read not answered");
    a_no_spurious: assert property (!rd_req.en |=> !rd_rsp.valid)
        else $error("answer without read");
    a_reserved_zero: assert property (rd_rsp.valid |-> (rd_rsp.data & 8'hcc) == 8'h00)
        else $error("reserved bit set");
    a_unmapped_zero: assert property (rd_req.en && !hit |=> rd_rsp.data == 8'h00)
        else $error("unmapped data");
    a_lock_live: assert property (rd_req.en && hit |=> rd_rsp.data[5] == $past(lock_lost_state[ci]))
        else $error("lock bit");
    a_signal_live: assert property (rd_req.en && hit |=> rd_rsp.data[4] == $past(signal_lost_state[ci]))
        else $error("signal bit");
    a_enable_mask: assert property (!(|{lock_change_irq_enable, signal_change_irq_enable}) |=> !irq)
        else $error("masked irq");
    a_lock_irq: assert property (prim_q && |((lock_lost_state ^ $past(lock_lost_state)) & lock_change_irq_enable)
        ##1 $stable(lock_change_irq_enable) |=> irq) else $error("no irq");
    a_irq_hold: assert property (irq && !$past(rd_req.en) && $stable(lock_change_irq_enable)
        && $stable(signal_change_irq_enable) |=> irq) else $error("irq dropped");
    c_read: cover property (rd_req.en && hit);
    c_unmapped: cover property (rd_req.en && !hit);
    c_irq: cover property ($rose(irq));
endmodule // cdra_alarm_irq_chk
bind cdra_alarm_irq cdra_alarm_irq_chk #(.NUM_CH(NUM_CH)) i_chk (.ref_clk, .rst, .lock_lost_state,
    .signal_lost_state, .lock_change_irq_enable, .signal_change_irq_enable, .rd_req, .rd_rsp, .irq);

/* File: verif/cdra_host_model.sv */
// Host model issuing register reads.
`timescale 1ns/1ps
module cdra_host_model
    import cdra_pkg::*;
(
    // Clock and read request.
    input  wire logic    ref_clk,
    output cdra_rd_req_s rd_req
);
    initial rd_req = '0;
    // A back-to-back call keeps the strobe high across edges.
    task automatic rd(input logic [7:0] a);
        rd_req <= '{1'b1, a};
        @(posedge ref_clk);
    endtask
    // Idle leaves the inverse address so a stale one cannot pass.
    task automatic idle();
        rd_req <= '{1'b0, ~rd_req.addr};
        @(posedge ref_clk);
    endtask
endmodule // cdra_host_model

/* File: verif/cdr_alarm_status_irq_bench.sv */
// Testbench of the alarm status block.
`timescale 1ns/1ps
module cdr_alarm_status_irq_bench;
    import cdra_pkg::*;
    logic         ref_clk = 0, rst = 1, irq;
    logic [3:0]   lk = 0, sg = 0, le = 0, se = 0, fl = 0, fs = 0;
    logic [31:0]  v;
    cdra_rd_req_s req;
    cdra_rd_rsp_s rsp;
    logic [7:0]   q[$];
    int           err_count = 0, checked = 0, cyc = 0, seed = 32'h0000_06c8;
    always #12.5 ref_clk = ~ref_clk;
    cdra_alarm_irq i_dut (.ref_clk(ref_clk), .rst(rst), .lock_lost_state(lk), .signal_lost_state(sg),
        .lock_change_irq_enable(le), .signal_change_irq_enable(se), .rd_req(req), .rd_rsp(rsp), .irq(irq));
    cdra_host_model i_host (.ref_clk(ref_clk), .rd_req(req));
    task automatic stop_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    // Flags are noted at read time, then cleared in the model.
    task automatic rd_ch(input int c);
        q.push_back({2'b00, lk[c], sg[c], 2'b00, fl[c], fs[c]});
        fl[c] = 1'b0;
        fs[c] = 1'b0;
        i_host.rd(CDRA_CH0_OFFS + 8'(8 * c));
    endtask
    // Each answer is paired with the oldest noted read; a hang ends the run.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rsp.valid === 1'b1) cmp("rd_data", q.size() > 0 ? q.pop_front() : 8'hxx, rsp.data);
        if (cyc > 2000) begin
            err_count++;
            stop_test();
        end
    end
    // Random levels and enables; reads come in some rounds so flags also pile up.
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int c = 0; c < 4; c++) rd_ch(c);
        i_host.idle();
        for (int r = 0; r < 40; r++) begin
            v = $random(seed);
            fl = fl | (lk ^ v[3:0]);
            fs = fs | (sg ^ v[7:4]);
            lk <= v[3:0];
            sg <= v[7:4];
            le <= v[11:8];
            se <= v[15:12];
            repeat (3) @(posedge ref_clk);
            cmp("irq", {7'h0, |(fl & le | fs & se)}, {7'h0, irq});
            if (v[16]) begin
                for (int c = 0; c < 4; c++) rd_ch(c);
                rd_ch(v[25:24]);
                q.push_back(8'h00);
                i_host.rd({v[23:19], 3'h3});
                i_host.idle();
                repeat (2) @(posedge ref_clk);
                cmp("irq", 8'h00, {7'h0, irq});
            end
        end
        cmp("queue", 8'h00, 8'(q.size()));
        stop_test();
    end
endmodule // cdr_alarm_status_irq_bench
